// file: logic/usm_pkg.sv
// constants and types for the clocked serial transceiver block
// Functional notes
// - clocked mode sends data bits only, no framing
// - one shared data line, half duplex
// - master mode from three selects; receive enables pick direction
// - master drives clock pin, driver auto enabled
// - master changes data on leading clock edge
// - exactly one clock cycle per data bit
// - polarity select sets idle level and edge
// - master transmit enables data and clock drivers
// - holding write waits for previous character end
// - empty shift register loads at once, shifts
// - data stable from one leading edge to next
// - optional ninth bit from ninth bit data
// - transmit enable starts transmit; receive enables cleared first
// - divisor pair plus speed selects set rate
// - in sleep only slave mode keeps running
// - slave shifts on external link clock
// - sleeping slave receiver accepts external word
// - full word received sets receive ready flag
// - reading receive data unloads; flag clears when empty
// - slave transmit reloads shift register, sets empty flag
// - holding register write clears transmit empty flag
// - receive ready flag is read only
// - two entry receive queue plus shifting third
package usm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BAUD_W = 18;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_TXD = 8'h08;
  localparam logic [7:0] ADDR_RXD = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  // control register fields
  localparam int CTRL_W = 11;
  localparam int CB_SYNC = 0;
  localparam int CB_MASTER = 1;
  localparam int CB_SERIAL_PORT_ENABLE = 2;
  localparam int CB_SINGLE_RECEIVE_ENABLE = 3;
  localparam int CB_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int CB_TRANSMIT_ENABLE = 5;
  localparam int CB_TX9 = 6;
  localparam int CB_NINTH_BIT_DATA = 7;
  localparam int CB_POL = 8;
  localparam int CB_FAST = 9;
  localparam int CB_WIDE = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  // status register fields
  localparam int SB_RX_READY = 0;
  localparam int SB_TX_EMPTY = 1;
  localparam int SB_TSR_EMPTY = 2;
  localparam int SB_OVERRUN = 3;
  // character lengths and baud prescale
  localparam logic [3:0] NBITS_8 = 4'h8;
  localparam logic [3:0] NBITS_9 = 4'h9;
  localparam logic [3:0] RX_LAST = 4'h7;
  localparam int PRESCALE_SHIFT = 2;
  localparam logic [BAUD_W-1:0] PRESCALE_PAD = 18'h00003;
  typedef enum logic [2:0] {
    CK_IDLE = 3'b001,
    CK_LOW = 3'b010,
    CK_HIGH = 3'b100
  } usm_clk_state_t;
endpackage : usm_pkg

// file: logic/usm_rx_fifo.sv
// two entry receive character queue with registered read data
`timescale 1ns/10ps
`default_nettype none
module usm_rx_fifo (
  input wire logic clock,
  input wire logic rst,
  input wire logic push,
  input wire logic [usm_pkg::DATA_W-1:0] wdata,
  input wire logic pop,
  output logic [usm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] count,
  output logic full
);
  import usm_pkg::*;
  logic [DATA_W-1:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic do_push;
  logic do_pop;

  assign do_pop = pop & (count_reg != 2'h0);
  assign do_push = push & ((count_reg != 2'h2) | do_pop);
  assign rdata = rdata_reg;
  assign count = count_reg;
  assign full = (count_reg == 2'h2);

  always_ff @(posedge clock)
  begin
    if (do_push)
    begin
      mem_reg[wr_ptr_reg] <= wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (do_push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (do_pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (do_push & ~do_pop)
        count_reg <= count_reg + 2'h1;
      else if (do_pop & ~do_push)
        count_reg <= count_reg - 2'h1;
    end
  end

  // head of queue kept in a register, bypassing an empty queue
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (do_pop)
    begin
      if (count_reg == 2'h2)
        rdata_reg <= mem_reg[~rd_ptr_reg];
      else if (do_push)
        rdata_reg <= wdata;
    end
    else if (do_push & (count_reg == 2'h0))
      rdata_reg <= wdata;
  end
endmodule : usm_rx_fifo
`default_nettype wire

// file: logic/usm_sync_core.sv
// clocked serial transceiver: apb registers, master clock, shift engines
`timescale 1ns/10ps
`default_nettype none
module usm_sync_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic link_clock_in,
  output logic link_clock_out,
  output logic link_clock_oe,
  input wire logic shared_data_in,
  output logic shared_data_out,
  output logic shared_data_oe,
  output logic receive_ready_flag,
  output logic transmit_empty_flag
);
  import usm_pkg::*;

  // ==========================================================
  // declarations
  logic [CTRL_W-1:0] ctrl_reg;
  logic [15:0] baud_reg;
  logic [8:0] hold_reg;
  logic hold_full_reg;
  logic overrun_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic dat_s1_reg, dat_s2_reg;
  usm_clk_state_t ck_reg;
  usm_clk_state_t ck_next;
  logic [BAUD_W-1:0] baud_cnt_reg;
  logic [8:0] tsr_reg;
  logic tsr_full_reg;
  logic [3:0] tx_cnt_reg;
  logic data_out_reg;
  logic [DATA_W-1:0] rsr_reg;
  logic [3:0] rx_cnt_reg;
  logic clk_out_reg, clk_oe_reg, data_oe_reg;
  logic rx_ready_reg, tx_empty_reg;
  logic [DATA_W-1:0] fifo_rdata;
  logic [1:0] fifo_count;
  logic fifo_full;
  logic setup, access_done;
  logic wr_ctrl, wr_baud, wr_tx, wr_stat, rd_rx;
  logic sync_on, master, pol, rx_cfg, tx_mode, rx_mode;
  logic [3:0] nbits;
  logic run, tick, lead_ev, trail_ev, slave_lead, slave_trail;
  logic tsr_load, tx_done, rx_take, push;

  function automatic logic [BAUD_W-1:0] baud_reload(input logic [15:0] div, input logic wide,
                                                    input logic fast);
    logic [BAUD_W-1:0] n;
    n = wide ? {2'b00, div} : {10'h000, div[7:0]};
    baud_reload = fast ? n : ((n << PRESCALE_SHIFT) | PRESCALE_PAD);
  endfunction : baud_reload

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_CTRL) | (a == ADDR_BAUD) | (a == ADDR_TXD) | (a == ADDR_RXD) | (a == ADDR_STAT);
  endfunction : is_mapped

  // ==========================================================
  // apb slave
  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign wr_ctrl = access_done & pwrite & (paddr == ADDR_CTRL);
  assign wr_baud = access_done & pwrite & (paddr == ADDR_BAUD);
  assign wr_tx = access_done & pwrite & (paddr == ADDR_TXD);
  assign wr_stat = access_done & pwrite & (paddr == ADDR_STAT);
  assign rd_rx = access_done & ~pwrite & (paddr == ADDR_RXD);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~is_mapped(paddr);
      if (setup & ~pwrite)
      begin
        case (paddr)
          ADDR_CTRL: prdata_reg <= {21'h000000, ctrl_reg};
          ADDR_BAUD: prdata_reg <= {16'h0000, baud_reg};
          ADDR_RXD: prdata_reg <= {24'h000000, fifo_rdata};
          ADDR_STAT: prdata_reg <= {28'h0000000, overrun_reg, ~tsr_full_reg, ~hold_full_reg,
                                    fifo_count != 2'h0};
          default: prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // control: in master mode single receive drops after one character unless continuous receive is set; software write wins
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_reg <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= pwdata[CTRL_W-1:0];
    else if (push & master & ~ctrl_reg[CB_CONTINUOUS_RECEIVE_ENABLE])
      ctrl_reg[CB_SINGLE_RECEIVE_ENABLE] <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      baud_reg <= BAUD_RESET;
    else if (wr_baud)
      baud_reg <= pwdata[15:0];
  end

  // holding register; ninth bit captured with the character
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hold_reg <= 9'h000;
      hold_full_reg <= 1'b0;
    end
    else if (wr_tx)
    begin
      hold_reg <= {ctrl_reg[CB_NINTH_BIT_DATA], pwdata[7:0]};
      hold_full_reg <= 1'b1;
    end
    else if (tsr_load)
      hold_full_reg <= 1'b0;
  end

  // overrun sticky: set wins over write-one clear
  always_ff @(posedge clock)
  begin
    if (rst)
      overrun_reg <= 1'b0;
    else if (push & fifo_full)
      overrun_reg <= 1'b1;
    else if (wr_stat & pwdata[SB_OVERRUN])
      overrun_reg <= 1'b0;
  end

  // ==========================================================
  // mode decode
  assign sync_on = ctrl_reg[CB_SERIAL_PORT_ENABLE] & ctrl_reg[CB_SYNC];
  assign master = ctrl_reg[CB_MASTER];
  assign pol = ctrl_reg[CB_POL];
  assign rx_cfg = ctrl_reg[CB_SINGLE_RECEIVE_ENABLE] | ctrl_reg[CB_CONTINUOUS_RECEIVE_ENABLE];
  assign tx_mode = sync_on & ~rx_cfg & ctrl_reg[CB_TRANSMIT_ENABLE];
  assign rx_mode = sync_on & rx_cfg;
  assign nbits = ctrl_reg[CB_TX9] ? NBITS_9 : NBITS_8;

  // ==========================================================
  // link pin synchronisers and slave edges
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      dat_s1_reg <= 1'b0;
      dat_s2_reg <= 1'b0;
    end
    else
    begin
      clk_s1_reg <= link_clock_in;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      dat_s1_reg <= shared_data_in;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  assign slave_lead = sync_on & ~master & (clk_s2_reg != clk_s3_reg) & (clk_s2_reg != pol);
  assign slave_trail = sync_on & ~master & (clk_s2_reg != clk_s3_reg) & (clk_s2_reg == pol);

  // ==========================================================
  // master clock generator
  assign run = sync_on & master & ~sleep_mode & ((tx_mode & tsr_full_reg) | (rx_mode & ~fifo_full));
  assign tick = (ck_reg != CK_IDLE) & (baud_cnt_reg == 18'h00000) & ~sleep_mode;

  always_ff @(posedge clock)
  begin
    if (rst | (ck_reg == CK_IDLE) | tick)
      baud_cnt_reg <= baud_reload(baud_reg, ctrl_reg[CB_WIDE], ctrl_reg[CB_FAST]);
    else if (~sleep_mode)
      baud_cnt_reg <= baud_cnt_reg - 18'h00001;
  end

  always_comb
  begin
    ck_next = ck_reg;
    case (ck_reg)
      CK_IDLE: if (run) ck_next = CK_LOW;
      CK_LOW:
      begin
        if (~run)
          ck_next = CK_IDLE;
        else if (tick)
          ck_next = CK_HIGH;
      end
      CK_HIGH: if (tick) ck_next = CK_IDLE;
      default: ck_next = CK_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      ck_reg <= CK_IDLE;
    else
      ck_reg <= ck_next;
  end

  assign lead_ev = master ? (tick & (ck_reg == CK_LOW)) : slave_lead;
  assign trail_ev = master ? (tick & (ck_reg == CK_HIGH)) : slave_trail;

  // ==========================================================
  // transmit engine
  assign tsr_load = tx_mode & ~tsr_full_reg & hold_full_reg;
  assign tx_done = tsr_full_reg & trail_ev & (tx_cnt_reg == nbits);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tsr_reg <= 9'h000;
      tsr_full_reg <= 1'b0;
      tx_cnt_reg <= 4'h0;
      data_out_reg <= 1'b0;
    end
    else if (~tx_mode)
    begin
      tsr_full_reg <= 1'b0;
      tx_cnt_reg <= 4'h0;
    end
    else if (tsr_load)
    begin
      tsr_reg <= hold_reg;
      tsr_full_reg <= 1'b1;
      tx_cnt_reg <= 4'h0;
    end
    else if (tsr_full_reg & lead_ev & (tx_cnt_reg != nbits))
    begin
      data_out_reg <= tsr_reg[0];
      tsr_reg <= {1'b0, tsr_reg[8:1]};
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
    end
    else if (tx_done)
      tsr_full_reg <= 1'b0;
  end

  // ==========================================================
  // receive engine
  assign rx_take = rx_mode & trail_ev;
  assign push = rx_take & (rx_cnt_reg == RX_LAST);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rsr_reg <= 8'h00;
      rx_cnt_reg <= 4'h0;
    end
    else if (~rx_mode)
      rx_cnt_reg <= 4'h0;
    else if (rx_take)
    begin
      rsr_reg <= {dat_s2_reg, rsr_reg[7:1]};
      rx_cnt_reg <= push ? 4'h0 : rx_cnt_reg + 4'h1;
    end
  end

  usm_rx_fifo u_rx_fifo (
    .clock(clock),
    .rst(rst),
    .push(push),
    .wdata({dat_s2_reg, rsr_reg[7:1]}),
    .pop(rd_rx),
    .rdata(fifo_rdata),
    .count(fifo_count),
    .full(fifo_full)
  );

  // ==========================================================
  // pin and flag outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      clk_out_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
      data_oe_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
    end
    else
    begin
      clk_out_reg <= pol ^ (ck_reg == CK_HIGH);
      clk_oe_reg <= sync_on & master;
      data_oe_reg <= tx_mode;
      rx_ready_reg <= (fifo_count != 2'h0);
      tx_empty_reg <= ~hold_full_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign link_clock_out = clk_out_reg;
  assign link_clock_oe = clk_oe_reg;
  assign shared_data_out = data_out_reg;
  assign shared_data_oe = data_oe_reg;
  assign receive_ready_flag = rx_ready_reg;
  assign transmit_empty_flag = tx_empty_reg;

  // ==========================================================
  // assertions
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // a holding write in the load cycle refills the holding register
  sequence s_load;
    tsr_load & ~wr_tx;
  endsequence
  sequence s_full_shift;
    tsr_full_reg & ~hold_full_reg;
  endsequence
  sequence s_empty_two;
    (fifo_count == 2'h0) [*2];
  endsequence

  property p_clk_driver;
    (sync_on & master) |=> link_clock_oe;
  endproperty
  a_clk_driver: assert property (p_clk_driver) else $error("clock driver off in master");

  property p_data_driver;
    (tx_mode & master) |=> (link_clock_oe & shared_data_oe);
  endproperty
  a_data_driver: assert property (p_data_driver) else $error("drivers off in transmit");

  property p_idle_level;
    (ck_reg == CK_IDLE) |=> (link_clock_out == $past(pol));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

  property p_data_on_lead;
    $changed(data_out_reg) |-> $past(lead_ev & tsr_full_reg);
  endproperty
  a_data_on_lead: assert property (p_data_on_lead) else $error("data moved off leading edge");

  property p_bit_count;
    tsr_full_reg |-> (tx_cnt_reg <= nbits);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("too many bits shifted");

  property p_load;
    s_load |=> s_full_shift;
  endproperty
  a_load: assert property (p_load) else $error("holding not moved to shifter");

  property p_empty_clear;
    (wr_tx & ~tsr_load) |=> ##1 ~transmit_empty_flag;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("empty flag not cleared");

  property p_ready_clear;
    s_empty_two |-> ~receive_ready_flag;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready flag with empty queue");

  property p_ready_set;
    (push & ~fifo_full) |=> ##1 receive_ready_flag;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set on word");

  property p_sleep_hold;
    (sleep_mode & (ck_reg == CK_IDLE)) |=> (ck_reg == CK_IDLE);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("master clock ran in sleep");

  property p_wait_previous;
    (tsr_full_reg & ~tx_done & tx_mode) |=> ~$past(tsr_load);
  endproperty
  a_wait_previous: assert property (p_wait_previous) else $error("new character cut in");

  property p_queue_depth;
    (fifo_full & push) |=> overrun_reg;
  endproperty
  a_queue_depth: assert property (p_queue_depth) else $error("overrun not flagged");
endmodule : usm_sync_core
`default_nettype wire

// file: test/usm_peer_model.sv
// link peer: clocks words as master, samples trailing edges
`timescale 1ns/10ps
`default_nettype none
module usm_peer_model (
  input wire logic ck_pin,
  input wire logic d_pin,
  input wire logic pol,
  output logic ck_drv,
  output logic d_drv,
  output logic d_oe
);
  logic q[$];
  int trail_n = 0;
  logic in_frame = 1'b0;
  logic ck_frame = 1'b0;
  // clock stands at idle level outside frames
  assign ck_drv = in_frame ? ck_frame : pol;
  initial
  begin
    d_drv = 1'b0;
    d_oe = 1'b0;
  end
  // ====================
  // trailing edge capture
  always @(ck_pin)
  begin
    if (ck_pin === pol)
    begin
      q.push_back(d_pin);
      trail_n++;
    end
  end
  // ====================
  // one word as link master, data bits only
  task automatic clock_word(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    in_frame = 1'b1;
    ck_frame = pol;
    d_oe = drive;
    for (int i = 0; i < 8; i++)
    begin
      d_drv = tx[i];
      #20 ck_frame = ~pol;
      #100 ck_frame = pol;
      #80 rx[i] = d_pin;
    end
    d_oe = 1'b0;
    in_frame = 1'b0;
  endtask : clock_word
endmodule : usm_peer_model
`default_nettype wire

// file: test/usm_sync_bench.sv
// bench: apb register access, master and slave link traffic
`timescale 1ns/10ps
`default_nettype none
module usart_synchronous_master_sleep_bench;
  import usm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic pol = 1'b0;
  logic d_last = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ck_out, ck_oe, d_out, d_oe, rx_rdy, tx_emp;
  logic ck_drv, p_d, p_doe, ck_pin, d_pin;
  logic [7:0] r;
  int num_errors = 0;
  int n_tests = 0;
  // released data line shows a changing pattern
  assign ck_pin = ck_oe ? ck_out : ck_drv;
  assign d_pin = d_oe ? d_out : (p_doe ? p_d : ~d_last);
  always #12.5 clock = ~clock;
  always @(posedge clock) d_last <= d_pin;
  usm_sync_core dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .link_clock_in(ck_pin), .link_clock_out(ck_out), .link_clock_oe(ck_oe),
    .shared_data_in(d_pin), .shared_data_out(d_out), .shared_data_oe(d_oe),
    .receive_ready_flag(rx_rdy), .transmit_empty_flag(tx_emp));
  usm_peer_model peer_u (.ck_pin(ck_pin), .d_pin(d_pin), .pol(pol), .ck_drv(ck_drv), .d_drv(p_d),
    .d_oe(p_doe));
  // ====================
  // report and compare
  task automatic print_verdict;
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // ====================
  // apb master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clock);
    end
    if (n == 20)
    begin
      num_errors++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 32'h0, x, e);
    chk(x, exp);
    chk({31'h0, e}, {31'h0, eexp});
  endtask : rd_chk
  task automatic clear_peer;
    cyc(3);
    peer_u.q.delete();
    peer_u.trail_n = 0;
  endtask : clear_peer
  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (peer_u.q.size() < n && k < 3000)
    begin
      k++;
      @(posedge clock);
    end
    if (k == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  endtask : wait_bits
  // ====================
  // master transmit of two back to back characters
  task automatic mtx(input logic p, input logic nine, input logic [7:0] a, input logic [7:0] b);
    logic [31:0] c;
    int nb;
    nb = nine ? 9 : 8;
    c = {21'h0, 1'b0, 1'b1, p, 1'b1, nine, 1'b1, 2'b00, 3'h7};
    pol <= p;
    wr(ADDR_BAUD, 32'h2);
    wr(ADDR_CTRL, c);
    rd_chk(ADDR_CTRL, c, 1'b0);
    clear_peer();
    chk(ck_pin, p);
    wr(ADDR_TXD, a);
    wr(ADDR_TXD, b);
    cyc(2);
    chk(tx_emp, 1'b0);
    chk({ck_oe, d_oe}, 2'b11);
    wait_bits(2 * nb);
    cyc(100);
    chk(peer_u.trail_n, 2 * nb);
    chk(ck_pin, p);
    for (int i = 0; i < nb; i++)
    begin
      chk(peer_u.q[i], i < 8 ? a[i] : 1'b1);
      chk(peer_u.q[nb + i], i < 8 ? b[i] : 1'b1);
    end
  endtask : mtx
  // ====================
  // main sequence
  initial
  begin
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk({tx_emp, rx_rdy, ck_oe, d_oe}, 4'h8);
    rd_chk(ADDR_STAT, 32'h6, 1'b0);
    rd_chk(8'h14, 32'h0, 1'b1);
    wr(8'h14, 32'hFF);
    mtx(1'b0, 1'b0, 8'hA6, 8'h35);
    mtx(1'b1, 1'b1, 8'h5C, 8'h81);
    // master clock halts in sleep
    clear_peer();
    sleep_mode <= 1'b1;
    wr(ADDR_TXD, 32'h0F);
    cyc(100);
    chk(peer_u.trail_n, 0);
    sleep_mode <= 1'b0;
    wait_bits(9);
    cyc(50);
    // sleeping slave receiver; port off while the idle clock level drops
    wr(ADDR_CTRL, 32'h0);
    pol <= 1'b0;
    cyc(4);
    wr(ADDR_CTRL, 32'h15);
    sleep_mode <= 1'b1;
    cyc(3);
    peer_u.clock_word(8'hA5, 1'b1, r);
    cyc(6);
    chk(rx_rdy, 1'b1);
    peer_u.clock_word(8'h3C, 1'b1, r);
    peer_u.clock_word(8'h0F, 1'b1, r);
    cyc(6);
    rd_chk(ADDR_STAT, 32'hF, 1'b0);
    wr(ADDR_STAT, 32'h3);
    rd_chk(ADDR_STAT, 32'hF, 1'b0);
    rd_chk(ADDR_RXD, 32'hA5, 1'b0);
    rd_chk(ADDR_RXD, 32'h3C, 1'b0);
    cyc(2);
    chk(rx_rdy, 1'b0);
    // sleeping slave transmitter
    wr(ADDR_STAT, 32'h8);
    wr(ADDR_CTRL, 32'h25);
    wr(ADDR_TXD, 32'h96);
    wr(ADDR_TXD, 32'h5A);
    cyc(2);
    chk(tx_emp, 1'b0);
    peer_u.clock_word(8'h00, 1'b0, r);
    chk(r, 8'h96);
    cyc(6);
    chk(tx_emp, 1'b1);
    peer_u.clock_word(8'h00, 1'b0, r);
    chk(r, 8'h5A);
    // master single receive
    sleep_mode <= 1'b0;
    wr(ADDR_CTRL, 32'h0F);
    clear_peer();
    chk({ck_oe, d_oe}, 2'b10);
    cyc(400);
    chk(peer_u.trail_n, 8);
    chk(rx_rdy, 1'b1);
    print_verdict();
  end
endmodule : usart_synchronous_master_sleep_bench
`default_nettype wire
